// >>> include/cpu_ops_pkg.sv
// Purpose: Shared types and constants for the stack, call and negate execution block
// Assumes: One instruction cycle is four clocks, one for each quarter phase
// Notes:   Offsets are register indices on the plain register port
package cpu_ops_pkg;
   typedef enum logic [1:0] {
      Q_DECODE = 2'b00,
      Q_READ   = 2'b01,
      Q_PROC   = 2'b10,
      Q_WRITE  = 2'b11
   } q_e;

   typedef enum logic [3:0] {
      OP_NOP    = 4'h0,
      OP_POP    = 4'h1,
      OP_PUSH   = 4'h2,
      OP_RESET  = 4'h3,
      OP_IRET   = 4'h4,
      OP_RELCALL = 4'h5,
      OP_NEGATE = 4'h6,
      OP_MULT   = 4'h7,
      OP_OTHER  = 4'h8
   } op_e;

   typedef struct packed {
      op_e         op;
      logic        bank_sel;
      logic        shadow_sel;
      logic [7:0]  file;
      logic [10:0] offset;
   } instr_s;

   // Encodings
   localparam logic [15:0] ENC_NOP   = 16'h0000;
   localparam logic [15:0] ENC_POP   = 16'h0006;
   localparam logic [15:0] ENC_PUSH  = 16'h0005;
   localparam logic [15:0] ENC_RESET = 16'h00ff;
   localparam logic [14:0] ENC_IRET  = 15'h0008;
   localparam logic [4:0]  ENC_RELCALL = 5'h1b;
   localparam logic [6:0]  ENC_NEGATE  = 7'h36;
   localparam logic [6:0]  ENC_MULT    = 7'h01;
   localparam logic [3:0]  ENC_NOP2  = 4'hf;

   // Flag positions
   localparam int FLG_C  = 0;
   localparam int FLG_HALF = 1;
   localparam int FLG_Z  = 2;
   localparam int FLG_OVF = 3;
   localparam int FLG_N  = 4;

   // Access bank split
   localparam logic [3:0] ACC_BANK_LO = 4'h0;
   localparam logic [3:0] ACC_BANK_HI = 4'hf;

   // Reset values and program counter step
   localparam logic [20:0] RST_PC   = 21'h000000;
   localparam logic [7:0]  RST_BYTE = 8'h00;
   localparam logic [20:0] PC_STEP  = 21'h000002;

   // Register indices
   localparam logic [4:0] REG_ACC    = 5'h00;
   localparam logic [4:0] REG_FLAGS  = 5'h01;
   localparam logic [4:0] REG_BANK   = 5'h02;
   localparam logic [4:0] REG_MUL_LO = 5'h03;
   localparam logic [4:0] REG_MUL_HI = 5'h04;
   localparam logic [4:0] REG_SPTR   = 5'h05;
   localparam logic [4:0] REG_TOSL   = 5'h06;
   localparam logic [4:0] REG_TOSH   = 5'h07;
   localparam logic [4:0] REG_TOSU   = 5'h08;
   localparam logic [4:0] REG_PCL    = 5'h09;
   localparam logic [4:0] REG_PCH    = 5'h0a;
   localparam logic [4:0] REG_PCU    = 5'h0b;
   localparam logic [4:0] REG_CTRL   = 5'h0c;
   localparam logic [4:0] REG_LATH   = 5'h0d;
   localparam logic [4:0] REG_LATU   = 5'h0e;
   localparam logic [4:0] REG_ACCSH  = 5'h10;
   localparam logic [4:0] REG_FLGSH  = 5'h11;
   localparam logic [4:0] REG_BANKSH = 5'h12;
   localparam logic [4:0] REG_MADRL  = 5'h14;
   localparam logic [4:0] REG_MADRH  = 5'h15;
   localparam logic [4:0] REG_MDATA  = 5'h16;

   // Control register bits
   localparam int CTL_IEN_HI = 0;
   localparam int CTL_IEN_LO = 1;
   localparam int CTL_RLOW = 2;
endpackage

// >>> rtl/cpu_stack_call_negate_ops.sv
// Purpose: Executes negate, multiply, push, pop, relative call, soft reset and return
// Assumes: Program memory presents the word at fetch_addr in the decode phase
// Notes:   Other opcodes pass as one idle cycle with the counter advanced
//
// The register offsets and the plain strobed port were left to the implementer.
module cpu_stack_call_negate_ops
   import cpu_ops_pkg::*;
#(
   parameter int STACK_DEPTH = 31
) (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        arst_n,
   // Program memory
   input  wire logic [15:0] instr_word,
   output logic      [20:0] fetch_addr,
   output q_e               q_phase,
   // Register port
   input  wire logic [4:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [7:0]  reg_rdata,
   // Status
   output logic             irq_en_high,
   output logic             irq_en_low,
   output logic             soft_reset_pulse
);
   q_e          q_r;
   instr_s      ir_r;
   logic        flush_r;
   logic [20:0] pc_r;
   logic [7:0]  acc_r, status_r, bank_ptr_r;
   logic [7:0]  acc_sh_r, flags_sh_r, bank_sh_r;
   logic [15:0] prod_r;
   logic [7:0]  pc_hi_lat_r, pc_up_lat_r;
   logic        gie_h_r, gie_l_r, ret_low_r;
   logic [4:0]  sptr_r;
   logic [20:0] stk [0:STACK_DEPTH];
   logic [7:0]  dmem [0:4095];
   logic [7:0]  opnd_r;
   logic [11:0] daddr_r;
   logic [11:0] mptr_r;
   logic [7:0]  rdata_r;
   logic        srst_r;
   logic        exec, srst;
   logic [20:0] stack_top, call_tgt;
   logic [7:0]  neg_res;

   function automatic instr_s decode(input logic [15:0] w);
      instr_s d;
      d.bank_sel   = w[8];
      d.shadow_sel = w[0];
      d.file       = w[7:0];
      d.offset     = w[10:0];
      if (w == ENC_NOP || w[15:12] == ENC_NOP2) begin
         d.op = OP_NOP;
      end else if (w == ENC_POP) begin
         d.op = OP_POP;
      end else if (w == ENC_PUSH) begin
         d.op = OP_PUSH;
      end else if (w == ENC_RESET) begin
         d.op = OP_RESET;
      end else if (w[15:1] == ENC_IRET) begin
         d.op = OP_IRET;
      end else if (w[15:11] == ENC_RELCALL) begin
         d.op = OP_RELCALL;
      end else if (w[15:9] == ENC_NEGATE) begin
         d.op = OP_NEGATE;
      end else if (w[15:9] == ENC_MULT) begin
         d.op = OP_MULT;
      end else begin
         d.op = OP_OTHER;
      end
      return d;
   endfunction

   function automatic logic [11:0] file_addr(input logic a, input logic [7:0] f,
                                             input logic [7:0] bank);
      if (a) begin
         file_addr = {bank[3:0], f};
      end else begin
         file_addr = {(f[7] ? ACC_BANK_HI : ACC_BANK_LO), f};
      end
   endfunction

   function automatic logic [20:0] next_pc(input logic [20:0] pc);
      next_pc = pc + PC_STEP;
   endfunction

   assign exec     = !flush_r;
   assign srst     = exec && q_r == Q_READ && ir_r.op == OP_RESET;
   assign stack_top = stk[sptr_r];
   assign neg_res  = ~opnd_r + 8'h01;
   assign call_tgt = next_pc(pc_r) + {{9{ir_r.offset[10]}}, ir_r.offset, 1'b0};

   assign fetch_addr       = pc_r;
   assign q_phase          = q_r;
   assign reg_rdata        = rdata_r;
   assign irq_en_high      = gie_h_r;
   assign irq_en_low       = gie_l_r;
   assign soft_reset_pulse = srst_r;

   // Phase sequencing and decode
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         q_r     <= Q_DECODE;
         ir_r    <= '0;
         flush_r <= 1'b0;
         srst_r  <= 1'b0;
      end else if (srst) begin
         q_r     <= Q_DECODE;
         ir_r    <= '0;
         flush_r <= 1'b0;
         srst_r  <= 1'b1;
      end else begin
         q_r    <= q_e'(q_r + 2'b01);
         srst_r <= 1'b0;
         if (q_r == Q_DECODE) begin
            ir_r <= decode(instr_word);
         end
         if (q_r == Q_WRITE) begin
            flush_r <= exec && (ir_r.op == OP_RELCALL || ir_r.op == OP_IRET);
         end
      end
   end

   // Program counter
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pc_r <= RST_PC;
      end else if (srst) begin
         pc_r <= RST_PC;
      end else if (q_r == Q_WRITE && exec) begin
         if (ir_r.op == OP_RELCALL) begin
            pc_r <= call_tgt;
         end else if (ir_r.op == OP_IRET) begin
            pc_r <= stack_top;
         end else begin
            pc_r <= next_pc(pc_r);
         end
      end
   end

   // Return stack
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         sptr_r <= 5'h00;
      end else if (srst) begin
         sptr_r <= 5'h00;
      end else if (exec) begin
         if (q_r == Q_READ && (ir_r.op == OP_PUSH || ir_r.op == OP_RELCALL)) begin
            if (sptr_r != 5'(STACK_DEPTH)) begin
               sptr_r <= sptr_r + 5'h01;
            end
         end else if ((q_r == Q_PROC && ir_r.op == OP_POP) ||
                      (q_r == Q_WRITE && ir_r.op == OP_IRET)) begin
            if (sptr_r != 5'h00) begin
               sptr_r <= sptr_r - 5'h01;
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (exec && q_r == Q_READ && (ir_r.op == OP_PUSH || ir_r.op == OP_RELCALL) &&
          sptr_r != 5'(STACK_DEPTH)) begin
         stk[sptr_r + 5'h01] <= next_pc(pc_r);
      end
   end

   // Operand fetch and data memory
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         opnd_r  <= RST_BYTE;
         daddr_r <= 12'h000;
      end else if (q_r == Q_READ) begin
         daddr_r <= file_addr(ir_r.bank_sel, ir_r.file, bank_ptr_r);
         opnd_r  <= dmem[file_addr(ir_r.bank_sel, ir_r.file, bank_ptr_r)];
      end
   end

   always_ff @(posedge clk) begin
      if (!srst && exec && q_r == Q_WRITE && ir_r.op == OP_NEGATE) begin
         dmem[daddr_r] <= neg_res;
      end else if (reg_wr && reg_addr == REG_MDATA) begin
         dmem[mptr_r] <= reg_wdata;
      end
   end

   // Working registers and flags
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         acc_r    <= RST_BYTE;
         status_r <= RST_BYTE;
         bank_ptr_r <= RST_BYTE;
         prod_r   <= 16'h0000;
      end else if (srst) begin
         acc_r    <= RST_BYTE;
         status_r <= RST_BYTE;
         bank_ptr_r <= RST_BYTE;
         prod_r   <= 16'h0000;
      end else begin
         if (reg_wr && reg_addr == REG_ACC) begin
            acc_r <= reg_wdata;
         end
         if (reg_wr && reg_addr == REG_FLAGS) begin
            status_r <= {3'b000, reg_wdata[4:0]};
         end
         if (reg_wr && reg_addr == REG_BANK) begin
            bank_ptr_r <= {4'h0, reg_wdata[3:0]};
         end
         if (exec && q_r == Q_WRITE) begin
            if (ir_r.op == OP_NEGATE) begin
               status_r[FLG_N]    <= neg_res[7];
               status_r[FLG_Z]    <= neg_res == 8'h00;
               status_r[FLG_OVF]  <= opnd_r == 8'h80;
               status_r[FLG_C]    <= opnd_r == 8'h00;
               status_r[FLG_HALF] <= opnd_r[3:0] == 4'h0;
            end else if (ir_r.op == OP_MULT) begin
               prod_r <= 16'(acc_r) * 16'(opnd_r);
            end else if (ir_r.op == OP_IRET && ir_r.shadow_sel) begin
               acc_r    <= acc_sh_r;
               status_r <= flags_sh_r;
               bank_ptr_r <= bank_sh_r;
            end
         end
      end
   end

   // Shadows, latches, enables, memory pointer
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         acc_sh_r   <= RST_BYTE;
         flags_sh_r <= RST_BYTE;
         bank_sh_r  <= RST_BYTE;
         pc_hi_lat_r <= RST_BYTE;
         pc_up_lat_r <= RST_BYTE;
         gie_h_r    <= 1'b0;
         gie_l_r    <= 1'b0;
         ret_low_r  <= 1'b0;
         mptr_r     <= 12'h000;
      end else if (srst) begin
         acc_sh_r   <= RST_BYTE;
         flags_sh_r <= RST_BYTE;
         bank_sh_r  <= RST_BYTE;
         pc_hi_lat_r <= RST_BYTE;
         pc_up_lat_r <= RST_BYTE;
         gie_h_r    <= 1'b0;
         gie_l_r    <= 1'b0;
         ret_low_r  <= 1'b0;
         mptr_r     <= 12'h000;
      end else begin
         if (reg_wr) begin
            if (reg_addr == REG_ACCSH) begin
               acc_sh_r <= reg_wdata;
            end else if (reg_addr == REG_FLGSH) begin
               flags_sh_r <= {3'b000, reg_wdata[4:0]};
            end else if (reg_addr == REG_BANKSH) begin
               bank_sh_r <= {4'h0, reg_wdata[3:0]};
            end else if (reg_addr == REG_LATH) begin
               pc_hi_lat_r <= reg_wdata;
            end else if (reg_addr == REG_LATU) begin
               pc_up_lat_r <= {3'b000, reg_wdata[4:0]};
            end else if (reg_addr == REG_CTRL) begin
               gie_h_r   <= reg_wdata[CTL_IEN_HI];
               gie_l_r   <= reg_wdata[CTL_IEN_LO];
               ret_low_r <= reg_wdata[CTL_RLOW];
            end else if (reg_addr == REG_MADRL) begin
               mptr_r[7:0] <= reg_wdata;
            end else if (reg_addr == REG_MADRH) begin
               mptr_r[11:8] <= reg_wdata[3:0];
            end
         end
         // Set wins over a same-cycle software clear
         if (exec && q_r == Q_WRITE && ir_r.op == OP_IRET) begin
            if (ret_low_r) begin
               gie_l_r <= 1'b1;
            end else begin
               gie_h_r <= 1'b1;
            end
         end
      end
   end

   // Register read port
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rdata_r <= RST_BYTE;
      end else if (reg_rd) begin
         if (reg_addr == REG_ACC) begin
            rdata_r <= acc_r;
         end else if (reg_addr == REG_FLAGS) begin
            rdata_r <= status_r;
         end else if (reg_addr == REG_BANK) begin
            rdata_r <= bank_ptr_r;
         end else if (reg_addr == REG_MUL_LO) begin
            rdata_r <= prod_r[7:0];
         end else if (reg_addr == REG_MUL_HI) begin
            rdata_r <= prod_r[15:8];
         end else if (reg_addr == REG_SPTR) begin
            rdata_r <= {3'b000, sptr_r};
         end else if (reg_addr == REG_TOSL) begin
            rdata_r <= stack_top[7:0];
         end else if (reg_addr == REG_TOSH) begin
            rdata_r <= stack_top[15:8];
         end else if (reg_addr == REG_TOSU) begin
            rdata_r <= {3'b000, stack_top[20:16]};
         end else if (reg_addr == REG_PCL) begin
            rdata_r <= pc_r[7:0];
         end else if (reg_addr == REG_PCH) begin
            rdata_r <= pc_r[15:8];
         end else if (reg_addr == REG_PCU) begin
            rdata_r <= {3'b000, pc_r[20:16]};
         end else if (reg_addr == REG_CTRL) begin
            rdata_r <= {5'b00000, ret_low_r, gie_l_r, gie_h_r};
         end else if (reg_addr == REG_LATH) begin
            rdata_r <= pc_hi_lat_r;
         end else if (reg_addr == REG_LATU) begin
            rdata_r <= pc_up_lat_r;
         end else if (reg_addr == REG_ACCSH) begin
            rdata_r <= acc_sh_r;
         end else if (reg_addr == REG_FLGSH) begin
            rdata_r <= flags_sh_r;
         end else if (reg_addr == REG_BANKSH) begin
            rdata_r <= bank_sh_r;
         end else if (reg_addr == REG_MADRL) begin
            rdata_r <= mptr_r[7:0];
         end else if (reg_addr == REG_MADRH) begin
            rdata_r <= {4'h0, mptr_r[11:8]};
         end else if (reg_addr == REG_MDATA) begin
            rdata_r <= dmem[mptr_r];
         end else begin
            rdata_r <= RST_BYTE;
         end
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);

   sequence s_op_at(op_e o, q_e q);
      exec && q_r == q && ir_r.op == o && !reg_wr;
   endsequence

   AST_NEG_FLAGS: assert property (s_op_at(OP_NEGATE, Q_WRITE) |=>
      status_r[FLG_Z] == ($past(opnd_r) == 8'h00) && status_r[FLG_N] == $past(neg_res[7]))
      else $error("negate flags wrong");
   AST_NEG_WRITE: assert property (s_op_at(OP_NEGATE, Q_WRITE) |=>
      dmem[$past(daddr_r)] == 8'(8'h00 - $past(opnd_r)))
      else $error("negate result not written back");
   AST_BANK_SEL: assert property (q_r == Q_READ && !ir_r.bank_sel |=>
      daddr_r[11:8] == ($past(ir_r.file[7]) ? ACC_BANK_HI : ACC_BANK_LO))
      else $error("access bank not used");
   AST_POP: assert property (s_op_at(OP_POP, Q_PROC) && sptr_r != 5'h00 |=>
      sptr_r == $past(sptr_r) - 5'h01 && $stable(status_r))
      else $error("pop did not drop top");
   AST_PUSH: assert property (s_op_at(OP_PUSH, Q_READ) && sptr_r != 5'h1f |=>
      stack_top == $past(pc_r) + PC_STEP)
      else $error("push value wrong");
   sequence s_call_push;
      s_op_at(OP_RELCALL, Q_READ) && sptr_r != 5'h1f;
   endsequence
   AST_CALL: assert property (s_call_push |-> ##3 pc_r == $past(call_tgt, 3) &&
      stack_top == $past(pc_r, 3) + PC_STEP)
      else $error("call target or return address wrong");
   AST_CALL_IDLE: assert property (s_op_at(OP_RELCALL, Q_WRITE) |=>
      flush_r ##1 (flush_r && $stable(pc_r)) [*3])
      else $error("call second cycle not idle");
   AST_IRET: assert property (s_op_at(OP_IRET, Q_WRITE) |=>
      pc_r == $past(stack_top) && (gie_h_r || gie_l_r) ##1 flush_r [*3])
      else $error("return did not pop into counter");
   AST_SHADOW: assert property (s_op_at(OP_IRET, Q_WRITE) && ir_r.shadow_sel |=>
      acc_r == $past(acc_sh_r) && bank_ptr_r == $past(bank_sh_r) &&
      status_r == $past(flags_sh_r) && $stable(pc_hi_lat_r) && $stable(pc_up_lat_r))
      else $error("shadow restore wrong");
   AST_NO_SHADOW: assert property (s_op_at(OP_IRET, Q_WRITE) && !ir_r.shadow_sel |=>
      $stable(acc_r) && $stable(status_r) && $stable(bank_ptr_r))
      else $error("registers changed without shadow select");
   AST_MUL: assert property (s_op_at(OP_MULT, Q_WRITE) |=>
      prod_r == 16'($past(acc_r)) * 16'($past(opnd_r)) && $stable(status_r))
      else $error("product wrong");
   AST_NOP: assert property (s_op_at(OP_NOP, Q_WRITE) |=>
      $stable(status_r) && $stable(sptr_r) && $stable(acc_r))
      else $error("no-operation changed state");
   AST_SRST: assert property (srst |=>
      pc_r == RST_PC && sptr_r == 5'h00 && acc_r == RST_BYTE && !gie_h_r && soft_reset_pulse)
      else $error("soft reset incomplete");
endmodule

// >>> testbench/cpu_stack_call_negate_ops_bench.sv
// Purpose: Self-checking bench for the stack, call and negate block
// Assumes: Program runs from the model memory, registers seen on the port
// Notes:   Each pass after reset is timed by the fetch address and the soft reset pulse, not by fixed counts
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin failures++; \
   $display("mismatch t=%0t got %h exp %h", $time, g, e); end end
module cpu_stack_call_negate_ops_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import cpu_ops_pkg::*;

   logic        clk;
   logic        arst_n;
   logic [15:0] instr_word;
   logic [20:0] fetch_addr;
   q_e          q_phase;
   logic [4:0]  reg_addr;
   logic [7:0]  reg_wdata;
   logic        reg_wr;
   logic        reg_rd;
   logic [7:0]  reg_rdata;
   logic        irq_en_high;
   logic        irq_en_low;
   logic        soft_reset_pulse;
   int          failures;
   int          n_checks;
   logic [31:0] lfsr_state;

   cpu_stack_call_negate_ops DUT (.clk(clk), .arst_n(arst_n), .instr_word(instr_word),
      .fetch_addr(fetch_addr), .q_phase(q_phase), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .irq_en_high(irq_en_high), .irq_en_low(irq_en_low),
      .soft_reset_pulse(soft_reset_pulse));
   prog_mem_model PM (.fetch_addr(fetch_addr), .instr_word(instr_word));

   always #2.5 clk = ~clk;

   function automatic logic [31:0] lfsr_next(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction

   // Expected flags after negating v: N OV Z DC C
   function automatic logic [7:0] neg_flags(input logic [7:0] v);
      logic [7:0] r;
      r = ~v + 8'h01;
      return {3'b000, r[7], v == 8'h80, r == 8'h00, v[3:0] == 4'h0, v == 8'h00};
   endfunction

   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [4:0] a, output logic [7:0] d);
      @(posedge clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(posedge clk);
      d = reg_rdata;
   endtask

   task automatic wait_pc(input logic [20:0] pc);
      int k;
      k = 0;
      while (fetch_addr !== pc && k < 2000) begin
         @(posedge clk);
         #1;
         k++;
      end
      `CHK(fetch_addr, pc)
   endtask

   task automatic results;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      failures++;
      $display("mismatch t=%0t watchdog expired", $time);
      results;
   end

   initial begin
      logic [7:0] v, r, a0, b, sa, sf, sb, d, d2;
      logic       s, abit, lows;
      int         k;
      clk = 1'b0;
      arst_n = 1'b0;
      reg_addr = 5'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      failures = 0;
      n_checks = 0;
      lfsr_state = 32'd91109;
      for (int w = 0; w < 256; w++) PM.mem[w] = ENC_NOP;
      PM.mem[10] = ENC_PUSH;
      PM.mem[11] = ENC_PUSH;
      PM.mem[12] = ENC_POP;
      PM.mem[13] = 16'hd8ba;
      PM.mem[150] = ENC_RESET;
      for (int i = 0; i < 4; i++) begin
         lfsr_state = lfsr_next(lfsr_state);
         v  = (i == 0) ? 8'h00 : (i == 1) ? 8'h80 : lfsr_state[7:0];
         a0 = lfsr_state[15:8];
         b  = {4'h0, lfsr_state[19:16] | 4'h1};
         sf = {3'b000, lfsr_state[24:20]};
         lfsr_state = lfsr_next(lfsr_state);
         sa = lfsr_state[7:0];
         sb = {4'h0, lfsr_state[11:8]};
         s = i[0];
         abit = i[1];
         lows = i[0] ^ i[1];
         PM.mem[8] = {ENC_NEGATE, abit, 8'h10};
         PM.mem[9] = {ENC_MULT, abit, 8'h10};
         PM.mem[200] = {ENC_IRET, s};
         arst_n <= 1'b0;
         repeat (16) @(posedge clk);
         arst_n <= 1'b1;
         // Setup finishes while words 0 to 7 idle
         wr(REG_ACC, a0);
         wr(REG_BANK, b);
         wr(REG_ACCSH, sa);
         wr(REG_FLGSH, sf);
         wr(REG_BANKSH, sb);
         wr(REG_CTRL, {5'h00, lows, 2'b00});
         wr(REG_MADRL, 8'h10);
         wr(REG_MADRH, 8'h00);
         wr(REG_MDATA, v);
         wr(REG_MADRH, b);
         wr(REG_MDATA, v);
         wait_pc(21'd400);
         rd(REG_SPTR, d);
         `CHK(d, 8'h02)
         rd(REG_TOSL, d);
         `CHK(d, 8'h1c)
         wait_pc(21'd28);
         rd(REG_SPTR, d);
         `CHK(d, 8'h01)
         rd(REG_TOSL, d);
         `CHK(d, 8'h16)
         `CHK(irq_en_high, ~lows)
         `CHK(irq_en_low, lows)
         rd(REG_ACC, d);
         `CHK(d, s ? sa : a0)
         rd(REG_FLAGS, d);
         `CHK(d, s ? sf : neg_flags(v))
         rd(REG_BANK, d);
         `CHK(d, s ? sb : b)
         r = ~v + 8'h01;
         wr(REG_MADRH, abit ? b : 8'h00);
         rd(REG_MDATA, d);
         `CHK(d, r)
         wr(REG_MADRH, abit ? 8'h00 : b);
         rd(REG_MDATA, d);
         `CHK(d, v)
         rd(REG_MUL_LO, d);
         rd(REG_MUL_HI, d2);
         `CHK({d2, d}, 16'(a0) * 16'(r))
         rd(5'h1f, d);
         `CHK(d, 8'h00)
         k = 0;
         while (soft_reset_pulse !== 1'b1 && k < 1000) begin
            @(posedge clk);
            #1;
            k++;
         end
         `CHK(soft_reset_pulse, 1'b1)
         `CHK(fetch_addr, RST_PC)
         `CHK(q_phase, Q_DECODE)
         `CHK(irq_en_high, 1'b0)
         rd(REG_SPTR, d);
         `CHK(d, RST_BYTE)
         rd(REG_ACC, d);
         `CHK(d, RST_BYTE)
      end
      results;
   end
endmodule

// >>> testbench/prog_mem_model.sv
// Purpose: Program memory model that hands instruction words to the core
// Assumes: Word index is fetch_addr bits 8:1, contents loaded by the bench
// Notes:   Combinational read, so a word stands through the whole cycle
module prog_mem_model (
   // Fetch side
   input  wire logic [20:0] fetch_addr,
   output logic      [15:0] instr_word
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [15:0] mem [256];

   assign instr_word = mem[fetch_addr[8:1]];
endmodule
